/* File: logic/chan_ctl_pkg.sv */
// Constants and types for the four-channel record/monitor selection logic.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
//
// Overview of operation
// - Each of four channels keeps its own record state, monitor source and indicators.
// - An inhibited channel never enters recording, whatever record command arrives.
// - After reset every channel is inhibited with its inhibit lamp lit.
// - Inhibit button with a channel button inhibits that channel and lights its lamp.
// - Inhibit press on a recording channel stops its recording and inhibits it.
// - An inhibited channel records again only after first being armed.
// - Dropping one channel from record leaves transport and other channels untouched.
// - Record-head monitor routes that head to the output and lights its lamp.
// - Record-head monitoring channel armed or recording switches to input monitoring.
// - Leaving record restores record-head monitoring unless another source was chosen.
// - After reset every channel monitors the reproduce head with its lamp lit.
// - Reproduce button with a channel button selects reproduce-head monitoring.
// - Input button with a channel button selects input monitoring.
// - Bias lamp lights while the channel records.
// - Erase lamp lights while the channel records.
// - Exactly one record state and exactly one monitor source per channel.
// - Play with record puts every armed channel into recording.
// - Arm button with a channel button arms that channel and lights its lamp.
package chan_ctl_pkg;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned NUM_BTN = 10;
  // Button vector bit positions
  localparam int unsigned BTN_CHAN0 = 0;
  localparam int unsigned BTN_ARM = 4;
  localparam int unsigned BTN_INHIBIT = 5;
  localparam int unsigned BTN_RECHEAD = 6;
  localparam int unsigned BTN_REPRO = 7;
  localparam int unsigned BTN_INPUT = 8;
  localparam int unsigned BTN_PLAYREC = 9;
  // Debounce time and cycle count at 40 MHz
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned DEBOUNCE_US = 100;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1000000));
  localparam int unsigned DB_W = 13;
  typedef enum logic [1:0] {REC_INHIBIT, REC_ARMED, REC_ACTIVE} rec_state_t;
  typedef enum logic [1:0] {MON_RECHEAD, MON_REPRO, MON_INPUT} mon_src_t;
  localparam rec_state_t REC_RESET = REC_INHIBIT;
  localparam mon_src_t MON_RESET = MON_REPRO;
endpackage

/* File: logic/btn_debounce.sv */
// Two-flop synchroniser and stability debouncer for a vector of pushbuttons.
// Assumes raw active-high button levels from the panel.
`timescale 1ns/1ps
module btn_debounce
  import chan_ctl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Raw and clean buttons
  input wire logic [NUM_BTN-1:0] raw,
  output logic [NUM_BTN-1:0] clean
);
  logic [NUM_BTN-1:0] sync1;
  logic [NUM_BTN-1:0] sync2;
  logic [NUM_BTN-1:0] last;
  logic [DB_W-1:0] cnt;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Whole vector must hold still, so a chord is released as one sample
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last <= '0;
      cnt <= '0;
      clean <= '0;
    end else begin
      last <= sync2;
      if (sync2 != last) begin
        cnt <= '0;
      end else if (cnt == DB_W'(DEBOUNCE_CYC - 1)) begin
        clean <= sync2;
      end else begin
        cnt <= cnt + DB_W'(1);
      end
    end
  end
endmodule

/* File: logic/chan_ctl.sv */
// Per-channel record-enable and monitor-source control with panel lamps.
// Assumes raw pushbutton levels on buttons; lamps and routing selects are registered.
`timescale 1ns/1ps
module chan_ctl
  import chan_ctl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Panel pushbuttons, see BTN_* positions
  input wire logic [NUM_BTN-1:0] buttons,
  // Record state lamps
  output logic [NUM_CHAN-1:0] inhibit_lamp,
  output logic [NUM_CHAN-1:0] armed_lamp,
  output logic [NUM_CHAN-1:0] record_lamp,
  // Monitor lamps, also the audio routing selects
  output logic [NUM_CHAN-1:0] rechead_lamp,
  output logic [NUM_CHAN-1:0] repro_lamp,
  output logic [NUM_CHAN-1:0] input_lamp,
  // Drive lamps
  output logic [NUM_CHAN-1:0] bias_lamp,
  output logic [NUM_CHAN-1:0] erase_lamp
);
  logic [NUM_BTN-1:0] clean;
  logic [NUM_BTN-1:0] prev;
  logic [NUM_BTN-1:0] press;
  rec_state_t rec [NUM_CHAN];
  mon_src_t mon [NUM_CHAN];
  logic [NUM_CHAN-1:0] want_rechead;

  btn_debounce u_db (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(buttons),
    .clean(clean)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= clean;
    end
  end

  // A function or channel button newly pressed while its partner is held counts once
  assign press = clean & ~prev;

  function automatic logic chord(input int unsigned ch, input int unsigned fn);
    return clean[BTN_CHAN0 + ch] && clean[fn] && (press[BTN_CHAN0 + ch] || press[fn]);
  endfunction

  function automatic logic mon_cmd(input int unsigned ch);
    return chord(ch, BTN_RECHEAD) || chord(ch, BTN_REPRO) || chord(ch, BTN_INPUT);
  endfunction

  // Record state per channel, each channel touched only by its own chord or by a play with record press
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_ch
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        rec[c] <= REC_RESET;
      end else if (chord(c, BTN_INHIBIT)) begin
        rec[c] <= REC_INHIBIT;
      end else if (chord(c, BTN_ARM)) begin
        rec[c] <= REC_ARMED;
      end else if (press[BTN_PLAYREC] && rec[c] == REC_ARMED) begin
        rec[c] <= REC_ACTIVE;
      end
    end

    // Remembers that record-head monitoring was chosen, so it returns after arming/recording
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        want_rechead[c] <= 1'b0;
        mon[c] <= MON_RESET;
      end else if (chord(c, BTN_RECHEAD)) begin
        want_rechead[c] <= 1'b1;
        mon[c] <= (rec[c] == REC_INHIBIT) ? MON_RECHEAD : MON_INPUT;
      end else if (chord(c, BTN_REPRO)) begin
        want_rechead[c] <= 1'b0;
        mon[c] <= MON_REPRO;
      end else if (chord(c, BTN_INPUT)) begin
        want_rechead[c] <= 1'b0;
        mon[c] <= MON_INPUT;
      end else if (want_rechead[c] && rec[c] != REC_INHIBIT) begin
        mon[c] <= MON_INPUT;
      end else if (want_rechead[c] && rec[c] == REC_INHIBIT) begin
        mon[c] <= MON_RECHEAD;
      end
    end

    // Lamps from state, one-hot in the record and monitor groups
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        inhibit_lamp[c] <= 1'b1;
        armed_lamp[c] <= 1'b0;
        record_lamp[c] <= 1'b0;
        rechead_lamp[c] <= 1'b0;
        repro_lamp[c] <= 1'b1;
        input_lamp[c] <= 1'b0;
        bias_lamp[c] <= 1'b0;
        erase_lamp[c] <= 1'b0;
      end else begin
        inhibit_lamp[c] <= (rec[c] == REC_INHIBIT);
        armed_lamp[c] <= (rec[c] == REC_ARMED);
        record_lamp[c] <= (rec[c] == REC_ACTIVE);
        rechead_lamp[c] <= (mon[c] == MON_RECHEAD);
        repro_lamp[c] <= (mon[c] == MON_REPRO);
        input_lamp[c] <= (mon[c] == MON_INPUT);
        bias_lamp[c] <= (rec[c] == REC_ACTIVE);
        erase_lamp[c] <= (rec[c] == REC_ACTIVE);
      end
    end

    property p_inhibit_no_rec;
      @(posedge ref_clk) disable iff (!rst_n)
        rec[c] == REC_INHIBIT |=> rec[c] != REC_ACTIVE;
    endproperty
    a_inhibit_no_rec: assert property (p_inhibit_no_rec) else $error("Inhibited channel entered record");

    property p_inhibit_chord;
      @(posedge ref_clk) disable iff (!rst_n)
        chord(c, BTN_INHIBIT) |=> rec[c] == REC_INHIBIT ##1 inhibit_lamp[c];
    endproperty
    a_inhibit_chord: assert property (p_inhibit_chord) else $error("Inhibit press not obeyed");

    property p_arm_chord;
      @(posedge ref_clk) disable iff (!rst_n)
        chord(c, BTN_ARM) && !chord(c, BTN_INHIBIT) |=> rec[c] == REC_ARMED ##1 armed_lamp[c];
    endproperty
    a_arm_chord: assert property (p_arm_chord) else $error("Arm press not obeyed");

    sequence s_playrec_armed;
      press[BTN_PLAYREC] && rec[c] == REC_ARMED && !chord(c, BTN_INHIBIT) && !chord(c, BTN_ARM);
    endsequence
    property p_playrec;
      @(posedge ref_clk) disable iff (!rst_n)
        s_playrec_armed |=> ##1 record_lamp[c] && !armed_lamp[c];
    endproperty
    a_playrec: assert property (p_playrec) else $error("Armed channel did not record");

    property p_only_via_armed;
      @(posedge ref_clk) disable iff (!rst_n)
        rec[c] == REC_ACTIVE && $past(rec[c]) != REC_ACTIVE |-> $past(rec[c]) == REC_ARMED;
    endproperty
    a_only_via_armed: assert property (p_only_via_armed) else $error("Record entered without arming");

    property p_bias_erase;
      @(posedge ref_clk) disable iff (!rst_n)
        ##1 (bias_lamp[c] == $past(rec[c] == REC_ACTIVE)) && (erase_lamp[c] == bias_lamp[c]);
    endproperty
    a_bias_erase: assert property (p_bias_erase) else $error("Bias or erase lamp wrong");

    property p_onehot;
      @(posedge ref_clk) disable iff (!rst_n)
        $onehot({inhibit_lamp[c], armed_lamp[c], record_lamp[c]})
        && $onehot({rechead_lamp[c], repro_lamp[c], input_lamp[c]});
    endproperty
    a_onehot: assert property (p_onehot) else $error("Lamp group not one-hot");

    property p_rechead_armed;
      @(posedge ref_clk) disable iff (!rst_n)
        mon[c] == MON_RECHEAD && rec[c] != REC_INHIBIT |=> mon[c] != MON_RECHEAD;
    endproperty
    a_rechead_armed: assert property (p_rechead_armed) else $error("Record head kept while armed");

    property p_repro_chord;
      @(posedge ref_clk) disable iff (!rst_n)
        chord(c, BTN_REPRO) && !chord(c, BTN_RECHEAD)
        |=> mon[c] == MON_REPRO ##1 repro_lamp[c];
    endproperty
    a_repro_chord: assert property (p_repro_chord) else $error("Reproduce press not obeyed");

    property p_input_chord;
      @(posedge ref_clk) disable iff (!rst_n)
        chord(c, BTN_INPUT) && !chord(c, BTN_RECHEAD) && !chord(c, BTN_REPRO)
        |=> mon[c] == MON_INPUT ##1 input_lamp[c];
    endproperty
    a_input_chord: assert property (p_input_chord) else $error("Input press not obeyed");

    property p_rechead_chord;
      @(posedge ref_clk) disable iff (!rst_n)
        chord(c, BTN_RECHEAD) && rec[c] == REC_INHIBIT
        |=> mon[c] == MON_RECHEAD ##1 rechead_lamp[c];
    endproperty
    a_rechead_chord: assert property (p_rechead_chord) else $error("Record head press not obeyed");

    property p_rechead_to_input;
      @(posedge ref_clk) disable iff (!rst_n)
        want_rechead[c] && rec[c] != REC_INHIBIT && !mon_cmd(c)
        |=> mon[c] == MON_INPUT ##1 input_lamp[c] && !rechead_lamp[c];
    endproperty
    a_rechead_to_input: assert property (p_rechead_to_input) else $error("Armed channel not on input");

    property p_rechead_restore;
      @(posedge ref_clk) disable iff (!rst_n)
        want_rechead[c] && rec[c] == REC_INHIBIT && !mon_cmd(c)
        |=> mon[c] == MON_RECHEAD ##1 rechead_lamp[c];
    endproperty
    a_rechead_restore: assert property (p_rechead_restore) else $error("Record head not restored");

    property p_want_clear;
      @(posedge ref_clk) disable iff (!rst_n)
        (chord(c, BTN_REPRO) || chord(c, BTN_INPUT)) && !chord(c, BTN_RECHEAD) |=> !want_rechead[c];
    endproperty
    a_want_clear: assert property (p_want_clear) else $error("Record head choice kept");

    // Stopping a recording takes the state first, then every drive lamp
    sequence s_inhibit_done;
      rec[c] == REC_INHIBIT ##1 inhibit_lamp[c] && !record_lamp[c] && !bias_lamp[c] && !erase_lamp[c];
    endsequence
    property p_inhibit_stop;
      @(posedge ref_clk) disable iff (!rst_n)
        rec[c] == REC_ACTIVE && chord(c, BTN_INHIBIT) |=> s_inhibit_done;
    endproperty
    a_inhibit_stop: assert property (p_inhibit_stop) else $error("Recording not stopped");

    property p_rec_hold;
      @(posedge ref_clk) disable iff (!rst_n)
        !chord(c, BTN_INHIBIT) && !chord(c, BTN_ARM) && !press[BTN_PLAYREC]
        |=> $stable(rec[c]);
    endproperty
    a_rec_hold: assert property (p_rec_hold) else $error("Record state changed without command");

    property p_active_stays;
      @(posedge ref_clk) disable iff (!rst_n)
        rec[c] == REC_ACTIVE && !chord(c, BTN_INHIBIT) && !chord(c, BTN_ARM) |=> rec[c] == REC_ACTIVE;
    endproperty
    a_active_stays: assert property (p_active_stays) else $error("Recording dropped");

    property p_playrec_inhibited;
      @(posedge ref_clk) disable iff (!rst_n)
        press[BTN_PLAYREC] && rec[c] == REC_INHIBIT && !chord(c, BTN_ARM)
        |=> rec[c] == REC_INHIBIT;
    endproperty
    a_playrec_inhibited: assert property (p_playrec_inhibited) else $error("Inhibited channel armed");

    property p_erase_record;
      @(posedge ref_clk) disable iff (!rst_n)
        erase_lamp[c] |-> record_lamp[c] && bias_lamp[c];
    endproperty
    a_erase_record: assert property (p_erase_record) else $error("Erase lamp without record");

    property p_bias_off;
      @(posedge ref_clk) disable iff (!rst_n)
        !record_lamp[c] |-> !bias_lamp[c];
    endproperty
    a_bias_off: assert property (p_bias_off) else $error("Bias lamp without record");

    property p_rec_lamps;
      @(posedge ref_clk) disable iff (!rst_n)
        ##1 inhibit_lamp[c] == $past(rec[c] == REC_INHIBIT)
        && armed_lamp[c] == $past(rec[c] == REC_ARMED)
        && record_lamp[c] == $past(rec[c] == REC_ACTIVE);
    endproperty
    a_rec_lamps: assert property (p_rec_lamps) else $error("Record lamps do not follow state");

    property p_mon_lamps;
      @(posedge ref_clk) disable iff (!rst_n)
        ##1 rechead_lamp[c] == $past(mon[c] == MON_RECHEAD)
        && repro_lamp[c] == $past(mon[c] == MON_REPRO)
        && input_lamp[c] == $past(mon[c] == MON_INPUT);
    endproperty
    a_mon_lamps: assert property (p_mon_lamps) else $error("Monitor lamps do not follow source");

    property p_state_legal;
      @(posedge ref_clk) disable iff (!rst_n)
        rec[c] inside {REC_INHIBIT, REC_ARMED, REC_ACTIVE}
        && mon[c] inside {MON_RECHEAD, MON_REPRO, MON_INPUT};
    endproperty
    a_state_legal: assert property (p_state_legal) else $error("Illegal channel state");

    property p_mon_hold;
      @(posedge ref_clk) disable iff (!rst_n)
        !mon_cmd(c) && !want_rechead[c] |=> $stable(mon[c]);
    endproperty
    a_mon_hold: assert property (p_mon_hold) else $error("Monitor source changed without command");

    // Armed waits for play with record; arming again is harmless
    sequence s_armed_wait;
      rec[c] == REC_ARMED && !chord(c, BTN_INHIBIT) && !press[BTN_PLAYREC];
    endsequence
    property p_armed_stays;
      @(posedge ref_clk) disable iff (!rst_n)
        s_armed_wait |=> rec[c] == REC_ARMED;
    endproperty
    a_armed_stays: assert property (p_armed_stays) else $error("Armed state lost");
  end

  property p_reset_state;
    @(posedge ref_clk) !rst_n |=> inhibit_lamp == '1 && repro_lamp == '1 && record_lamp == '0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Reset lamps wrong");

  // A held chord must not act twice
  property p_press_once;
    @(posedge ref_clk) disable iff (!rst_n)
      |press |=> (press & $past(press)) == '0;
  endproperty
  a_press_once: assert property (p_press_once) else $error("Press lasted more than one cycle");

  property p_prev_follow;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 prev == $past(clean);
  endproperty
  a_prev_follow: assert property (p_prev_follow) else $error("Edge detector lags");
endmodule

/* File: dv/panel_model.sv */
// Operator front panel: presses chords of buttons on the raw button lines.
// Assumes the control block's clock; a released button reads low.
`timescale 1ns/1ps
module panel_model
  import chan_ctl_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Raw buttons
  output logic [NUM_BTN-1:0] buttons
);
  initial buttons = '0;

  // Held well past the debounce time so a chord is seen exactly once
  task automatic chord(input logic [3:0] chans, input int fn);
    logic [NUM_BTN-1:0] v;
    v = {{(NUM_BTN - 4){1'b0}}, chans};
    v[fn] = 1'b1;
    @(negedge ref_clk);
    buttons = v;
    repeat (DEBOUNCE_CYC + 10) @(negedge ref_clk);
    buttons = '0;
    repeat (DEBOUNCE_CYC + 10) @(negedge ref_clk);
  endtask
endmodule

/* File: dv/chan_ctl_tb.sv */
// Self-checking bench for the per-channel record and monitor control.
// Assumes the panel model drives every button; lamps are checked after each chord.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module chan_ctl_tb
  import chan_ctl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_BTN-1:0] buttons;
  logic [NUM_CHAN-1:0] inh, arm, rl, rh, rp, inp, bias, erase;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int rec [NUM_CHAN];
  int mon [NUM_CHAN];

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  panel_model u_panel (.ref_clk(ref_clk), .buttons(buttons));

  chan_ctl DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .buttons(buttons),
    .inhibit_lamp(inh), .armed_lamp(arm), .record_lamp(rl),
    .rechead_lamp(rh), .repro_lamp(rp), .input_lamp(inp),
    .bias_lamp(bias), .erase_lamp(erase)
  );

  task automatic finish_test();
    $display("Checks: %0d, errors: %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Ceiling sits above nine chords of about 8020 cycles each
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic apply(input logic [3:0] chans, input int fn);
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (fn == BTN_PLAYREC && rec[i] == REC_ARMED) rec[i] = REC_ACTIVE;
      if (chans[i]) begin
        case (fn)
          BTN_ARM: rec[i] = REC_ARMED;
          BTN_INHIBIT: rec[i] = REC_INHIBIT;
          BTN_RECHEAD: mon[i] = MON_RECHEAD;
          BTN_REPRO: mon[i] = MON_REPRO;
          BTN_INPUT: mon[i] = MON_INPUT;
          default: ;
        endcase
      end
    end
  endtask

  task automatic check_all();
    logic [NUM_CHAN-1:0] ei, ea, er, eh, ep, en;
    for (int i = 0; i < NUM_CHAN; i++) begin
      ei[i] = (rec[i] == REC_INHIBIT);
      ea[i] = (rec[i] == REC_ARMED);
      er[i] = (rec[i] == REC_ACTIVE);
      eh[i] = (mon[i] == MON_RECHEAD) && ei[i];
      ep[i] = (mon[i] == MON_REPRO);
      en[i] = (mon[i] == MON_INPUT) || ((mon[i] == MON_RECHEAD) && !ei[i]);
    end
    `CHK(inh, ei)
    `CHK(arm, ea)
    `CHK(rl, er)
    `CHK(rh, eh)
    `CHK(rp, ep)
    `CHK(inp, en)
    `CHK(bias, er)
    `CHK(erase, er)
  endtask

  task automatic step(input logic [3:0] chans, input int fn);
    u_panel.chord(chans, fn);
    apply(chans, fn);
    check_all();
  endtask

  initial begin
    void'($urandom(87691));
    for (int i = 0; i < NUM_CHAN; i++) begin
      rec[i] = REC_RESET;
      mon[i] = MON_RESET;
    end
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check_all();
    step(4'h1, BTN_RECHEAD);
    step(4'h3, BTN_ARM);
    step(4'h0, BTN_PLAYREC);
    step(4'h1, BTN_INHIBIT);
    step(4'h0, BTN_PLAYREC);
    step(4'($urandom()), BTN_INPUT);
    step(4'($urandom()), BTN_REPRO);
    step(4'h1, BTN_ARM);
    step(4'h0, BTN_PLAYREC);
    finish_test();
  end
endmodule
